// ==== rtl/term_pkg.sv ====
// constants, types and latency functions for the termination selector
package term_pkg;

  // ***************************************************************
  // register map (wishbone byte addresses)
  // ***************************************************************
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // control word fields
  localparam int unsigned CWL_LSB = 0;
  localparam int unsigned CWL_W = 5;
  localparam int unsigned AL_LSB = 5;
  localparam int unsigned AL_W = 4;
  localparam int unsigned PL_LSB = 9;
  localparam int unsigned PL_W = 3;
  localparam int unsigned PRE2_BIT = 12;
  localparam int unsigned CRC_BIT = 13;
  localparam int unsigned DLL_OFF_BIT = 14;
  localparam int unsigned WRT_LSB = 15;
  localparam int unsigned WRT_W = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0009;
  localparam logic [31:0] CTRL_MASK = 32'h0003_ffff;

  // status word fields
  localparam int unsigned ST_TERM_LSB = 0;
  localparam int unsigned ST_ASYNC_BIT = 3;
  localparam int unsigned ST_PEND_BIT = 4;

  // ***************************************************************
  // latency figures in clock cycles
  // ***************************************************************
  localparam int unsigned LAT_W = 6;
  localparam int unsigned DLY_DEPTH = 64;
  localparam logic [5:0] PRE1_SUB = 6'h02;
  localparam logic [5:0] PRE2_SUB = 6'h03;
  localparam logic [5:0] MIN_LAT = 6'h01;
  localparam logic [5:0] CHOP_P1_NOCRC = 6'h04;
  localparam logic [5:0] CHOP_P1_CRC = 6'h07;
  localparam logic [5:0] CHOP_P2_NOCRC = 6'h05;
  localparam logic [5:0] CHOP_P2_CRC = 6'h08;
  localparam logic [5:0] FULL_P1_NOCRC = 6'h06;
  localparam logic [5:0] FULL_P1_CRC = 6'h07;
  localparam logic [5:0] FULL_P2_NOCRC = 6'h07;
  localparam logic [5:0] FULL_P2_CRC = 6'h08;

  // one-hot termination strength selection
  typedef enum logic [2:0] {
    TERM_PARK = 3'b001,
    TERM_NOM = 3'b010,
    TERM_WR = 3'b100
  } term_type;

  // write latency less the preamble allowance, never below one cycle
  function automatic logic [5:0] switch_on_lat(input logic [5:0] wl,
                                               input logic pre2);
    logic [5:0] sub;
    sub = pre2 ? PRE2_SUB : PRE1_SUB;
    if (wl <= sub + MIN_LAT) begin
      return MIN_LAT;
    end
    return wl - sub;
  endfunction

  // cycles from switch-on to switch-off of write termination
  function automatic logic [5:0] switch_off_add(input logic chop,
                                                input logic pre2,
                                                input logic crc);
    if (chop) begin
      if (pre2) begin
        return crc ? CHOP_P2_CRC : CHOP_P2_NOCRC;
      end
      return crc ? CHOP_P1_CRC : CHOP_P1_NOCRC;
    end
    if (pre2) begin
      return crc ? FULL_P2_CRC : FULL_P2_NOCRC;
    end
    return crc ? FULL_P1_CRC : FULL_P1_NOCRC;
  endfunction

endpackage

// ==== rtl/odt_delay_line.sv ====
// programmable delay of the termination control pin
`timescale 1ns/1ps
`default_nettype none

module odt_delay_line (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic din,
  input wire logic [term_pkg::LAT_W-1:0] lat,
  output logic dout
);

  logic [term_pkg::DLY_DEPTH-1:0] shift_r;

  // one stage per cycle; stage k holds the pin sampled k+1 edges ago
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (ce) begin
      shift_r <= {shift_r[term_pkg::DLY_DEPTH-2:0], din};
    end
  end

  // tap lat-1 so the consumer's register lands exactly lat edges later
  assign dout = shift_r[lat - term_pkg::MIN_LAT];

endmodule // odt_delay_line

`default_nettype wire

// ==== rtl/term_select.sv ====
// termination strength selector with wishbone control registers
`timescale 1ns/1ps
`default_nettype none

module term_select (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic WR_CMD,
  input wire logic WR_CHOP,
  input wire logic ODT_PIN,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic [2:0] TERM_SEL,
  output logic ASYNC_MODE
);

  // ***************************************************************
  // reset release
  // ***************************************************************
  logic rst_meta_r;
  logic rst_sync_n;

  // async assert, two-flop release so all state leaves reset together
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ***************************************************************
  // wishbone slave
  // ***************************************************************
  logic [31:0] ctrl_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic req;
  logic wr_ctrl;
  logic [31:0] stat_word;
  term_pkg::term_type term_r;
  term_pkg::term_type term_nxt;
  logic pend_r;
  logic pend_nxt;

  assign req = CYC_I && STB_I;
  assign wr_ctrl = req && ack_r && WE_I && (ADR_I == term_pkg::CTRL_OFS);

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_r <= 1'b0;
    end else if (CE) begin
      ack_r <= req && !ack_r;
    end
  end

  // control word, byte lanes honoured; write lands on the ack edge
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_r <= term_pkg::CTRL_RST;
    end else if (CE && wr_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (SEL_I[b]) begin
          ctrl_r[b*8 +: 8] <= DAT_I[b*8 +: 8] & term_pkg::CTRL_MASK[b*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    stat_word = '0;
    stat_word[term_pkg::ST_TERM_LSB +: 3] = term_r;
    stat_word[term_pkg::ST_ASYNC_BIT] = ASYNC_MODE;
    stat_word[term_pkg::ST_PEND_BIT] = pend_r;
  end

  // read data captured at request so it is steady while ack is high;
  // unmapped addresses read zero and ignore writes
  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dat_r <= '0;
    end else if (CE && req && !ack_r) begin
      if (ADR_I == term_pkg::CTRL_OFS) begin
        dat_r <= ctrl_r;
      end else if (ADR_I == term_pkg::STAT_OFS) begin
        dat_r <= stat_word;
      end else begin
        dat_r <= '0;
      end
    end
  end

  assign DAT_O = dat_r;
  assign ACK_O = ack_r;

  // ***************************************************************
  // configuration decode
  // ***************************************************************
  logic [5:0] wl;
  logic pre2;
  logic crc;
  logic dll_off;
  logic [2:0] wrt_field;
  logic dyn_en;
  logic [5:0] on_lat;

  // write latency = cwl + al + pl, widened before summing
  assign wl = 6'(ctrl_r[term_pkg::CWL_LSB +: term_pkg::CWL_W])
            + 6'(ctrl_r[term_pkg::AL_LSB +: term_pkg::AL_W])
            + 6'(ctrl_r[term_pkg::PL_LSB +: term_pkg::PL_W]);
  assign pre2 = ctrl_r[term_pkg::PRE2_BIT];
  assign crc = ctrl_r[term_pkg::CRC_BIT];
  assign dll_off = ctrl_r[term_pkg::DLL_OFF_BIT];
  assign wrt_field = ctrl_r[term_pkg::WRT_LSB +: term_pkg::WRT_W];
  assign dyn_en = (wrt_field[1:0] != 2'b00) && !dll_off;
  assign on_lat = term_pkg::switch_on_lat(wl, pre2);
  assign ASYNC_MODE = dll_off;

  // ***************************************************************
  // nominal request from the control pin
  // ***************************************************************
  logic odt_dly;
  logic nom_req;

  // same latency as write switch-on: cwl + al + pl less preamble
  odt_delay_line u_dly (
    .clk(CLK),
    .rst_n(rst_sync_n),
    .ce(CE),
    .din(ODT_PIN),
    .lat(on_lat),
    .dout(odt_dly)
  );

  // async mode takes the pin as sampled, no al or pl added
  assign nom_req = dll_off ? ODT_PIN : odt_dly;

  // ***************************************************************
  // write termination window
  // ***************************************************************
  logic wr_take;
  logic chop_r;
  logic [5:0] age_r;
  logic [5:0] age_nxt;
  logic [5:0] cnw_r;
  logic [5:0] cwn_r;
  logic [5:0] cnw_nxt;
  logic [5:0] cwn_nxt;

  assign wr_take = CE && WR_CMD && dyn_en;

  // a new write restarts the count; latencies frozen per write so a
  // register change mid-window cannot tear the window
  always_comb begin
    pend_nxt = pend_r;
    age_nxt = age_r;
    cnw_nxt = cnw_r;
    cwn_nxt = cwn_r;
    if (wr_take) begin
      pend_nxt = 1'b1;
      age_nxt = '0;
      cnw_nxt = on_lat;
      cwn_nxt = on_lat
        + term_pkg::switch_off_add(WR_CHOP, pre2, crc);
    end else if (pend_r) begin
      age_nxt = age_r + 6'h01;
      pend_nxt = (age_nxt != cwn_r);
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_r <= 1'b0;
      age_r <= '0;
      cnw_r <= term_pkg::MIN_LAT;
      cwn_r <= term_pkg::MIN_LAT;
      chop_r <= 1'b0;
    end else if (CE) begin
      pend_r <= pend_nxt;
      age_r <= age_nxt;
      cnw_r <= cnw_nxt;
      cwn_r <= cwn_nxt;
      if (wr_take) begin
        chop_r <= WR_CHOP;
      end
    end
  end

  // ***************************************************************
  // strength selection
  // ***************************************************************
  // write strength held across back-to-back writes until the last ends
  always_comb begin
    if (pend_nxt && (term_r == term_pkg::TERM_WR || age_nxt == cnw_nxt)) begin
      term_nxt = term_pkg::TERM_WR;
    end else if (nom_req) begin
      term_nxt = term_pkg::TERM_NOM;
    end else begin
      term_nxt = term_pkg::TERM_PARK;
    end
  end

  always_ff @(posedge CLK or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      term_r <= term_pkg::TERM_PARK;
    end else if (CE) begin
      term_r <= term_nxt;
    end
  end

  assign TERM_SEL = term_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_sync_n);

  AST_WR_ON: assert property (
    CE && !wr_take && pend_r && term_r != term_pkg::TERM_WR
    && age_r + 6'h01 == cnw_r |=> term_r == term_pkg::TERM_WR)
    else $error("write termination not on at switch-on latency");

  AST_CHOP_OFF: assert property (
    CE && !wr_take && pend_r && chop_r && term_r == term_pkg::TERM_WR
    && age_r + 6'h01 == cwn_r |=> term_r != term_pkg::TERM_WR
    && $past(cwn_r) == $past(cnw_r)
       + (pre2 ? (crc ? 6'h08 : 6'h05) : (crc ? 6'h07 : 6'h04)))
    else $error("chopped write window wrong length");

  AST_FULL_OFF: assert property (
    CE && !wr_take && pend_r && !chop_r && term_r == term_pkg::TERM_WR
    && age_r + 6'h01 == cwn_r |=> term_r != term_pkg::TERM_WR
    && $past(cwn_r) == $past(cnw_r)
       + (pre2 ? (crc ? 6'h08 : 6'h07) : (crc ? 6'h07 : 6'h06)))
    else $error("full write window wrong length");

  AST_ASYNC_SEL: assert property (
    dll_off |-> ASYNC_MODE && !pend_r ##1 !pend_r || $changed(ctrl_r))
    else $error("async mode not selected with dll off");

  AST_ASYNC_FALL: assert property (
    CE && dll_off && !ODT_PIN && !pend_nxt && !wr_ctrl
    |=> term_r == term_pkg::TERM_PARK)
    else $error("async mode did not park on pin low");

  AST_ASYNC_RISE: assert property (
    CE && dll_off && ODT_PIN && !pend_nxt && !wr_ctrl
    |=> term_r == term_pkg::TERM_NOM)
    else $error("async mode did not go nominal on pin high");

  AST_DYN_GATE: assert property (
    CE && WR_CMD && wrt_field[1:0] == 2'b00 && !pend_r |=> !pend_r)
    else $error("write window opened with dynamic termination off");

  AST_SYNC_NOM: assert property (
    CE && !dll_off && !pend_nxt && on_lat == term_pkg::MIN_LAT
    && $stable(on_lat) |=> term_r == ($past(ODT_PIN, 2)
    ? term_pkg::TERM_NOM : term_pkg::TERM_PARK))
    else $error("nominal termination not timed from the pin");

  AST_DLL_WR: assert property (
    CE && WR_CMD && dll_off && !pend_r |=> !pend_r)
    else $error("write window opened with dll off");

  AST_END_RET: assert property (
    $past(CE) && $past(term_r) == term_pkg::TERM_WR
    && term_r != term_pkg::TERM_WR
    |-> term_r == ($past(nom_req) ? term_pkg::TERM_NOM : term_pkg::TERM_PARK))
    else $error("wrong strength after write window");

  COV_CHOP: cover property (CE && wr_take && WR_CHOP ##[1:80]
    term_r == term_pkg::TERM_WR);
  COV_FULL_CRC: cover property (CE && wr_take && !WR_CHOP && crc ##[1:80]
    term_r == term_pkg::TERM_WR);
  COV_ASYNC: cover property (dll_off && term_r == term_pkg::TERM_NOM);
  COV_BACK2BACK: cover property (wr_take && term_r == term_pkg::TERM_WR);

endmodule // term_select

`default_nettype wire

// ==== test/ctrl_model.sv ====
// behavioural memory controller driving write commands and the control pin
`timescale 1ns/1ps
`default_nettype none

module ctrl_model (
  input wire logic clk,
  output logic wr_cmd,
  output logic wr_chop,
  output logic odt_pin
);
  // ***************************************************************
  // idle levels
  // ***************************************************************
  initial begin
    wr_cmd = 1'b0;
    wr_chop = 1'b0;
    odt_pin = 1'b0;
  end

  // one-cycle write command; returns at the edge that registers it
  task automatic send_write(input logic chop);
    @(posedge clk);
    wr_cmd <= 1'b1;
    wr_chop <= chop;
    @(posedge clk);
    wr_cmd <= 1'b0;
    wr_chop <= ~chop; // qualifier released: no stale value left behind
  endtask

  // pin level change; returns at the edge that samples the new level
  task automatic set_odt(input logic lvl);
    @(posedge clk);
    odt_pin <= lvl; // level held until the next call
    @(posedge clk);
  endtask
endmodule // ctrl_model

`default_nettype wire

// ==== test/term_select_test.sv ====
// self-checking bench for the termination selector
`timescale 1ns/1ps
`default_nettype none

module term_select_test;
  logic clk, rst_n, ce, cyc, stb, we;
  logic [3:0] adr, sel;
  logic [31:0] dat_i, dat_o, rd;
  logic ack, async_mode;
  logic [2:0] term;
  wire logic wr_cmd, wr_chop, odt_pin;
  int bad_count, checks;
  int on_lat, off_lat;
  logic [31:0] cw;

  term_select dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .WR_CMD(wr_cmd),
    .WR_CHOP(wr_chop), .ODT_PIN(odt_pin), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o),
    .ACK_O(ack), .TERM_SEL(term), .ASYNC_MODE(async_mode));
  ctrl_model ctrl (.clk(clk), .wr_cmd(wr_cmd), .wr_chop(wr_chop),
    .odt_pin(odt_pin));

  // ***************************************************************
  // clock, verdict and shared tasks
  // ***************************************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // let n edges pass, then sample once their updates have landed
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // classic cycle: request held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      print_verdict();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    dat_i <= ~d; // released data does not keep its last value
  endtask

  // one write window: switch-on, hold and switch-off instants
  task automatic window(input logic chop, input logic [2:0] prior,
                        input logic [2:0] after);
    ctrl.send_write(chop);
    edges(on_lat - 1);
    check("term before switch-on", {29'h0, prior}, {29'h0, term});
    edges(1);
    check("term at switch-on", 32'h4, {29'h0, term});
    edges(off_lat - 1);
    check("term before switch-off", 32'h4, {29'h0, term});
    edges(1);
    check("term after window", {29'h0, after}, {29'h0, term});
  endtask

  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {cyc, stb, we} = 3'h0;
    adr = 4'h0;
    sel = 4'h0;
    dat_i = 32'h0;
    bad_count = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // register map: reset value, lanes, read-only status, unmapped place
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    check("ctrl reset", 32'h9, rd);
    wb(1'b1, 4'h0, 4'h1, 32'hffff_ffff);
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    check("ctrl one lane", 32'hff, rd);
    wb(1'b1, 4'h0, 4'hf, 32'hffff_ffff);
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    check("ctrl upper bits", 32'h0003_ffff, rd);
    wb(1'b1, 4'h0, 4'hf, 32'h9);
    wb(1'b1, 4'h4, 4'hf, 32'hffff_ffff);
    wb(1'b0, 4'h4, 4'hf, 32'h0);
    check("status read-only", 32'h1, rd);
    wb(1'b1, 4'hb, 4'hf, 32'hffff_ffff);
    wb(1'b0, 4'h8, 4'hf, 32'h0);
    check("unmapped read", 32'h0, rd);
    edges(0);
    check("ack dropped", 32'h0, {31'h0, ack});
    wb(1'b0, 4'h3, 4'hf, 32'h0);
    check("odd address read", 32'h0, rd);
    wb(1'b0, 4'h0, 4'hf, 32'h0);
    check("ctrl after unmapped", 32'h9, rd);
    // every preamble, crc and length mode; odd cases add one cycle of AL
    for (int i = 0; i < 8; i++) begin
      cw = 32'h9 | (32'(i & 1) << 5) | (32'(i >> 1 & 1) << 12);
      cw = cw | (32'(i >> 2) << 13) | (32'h1 << 15);
      on_lat = 9 + (i & 1) - ((i >> 1 & 1) != 0 ? 3 : 2);
      off_lat = (i & 1) != 0 ? ((i & 2) != 0 ? ((i & 4) != 0 ? 8 : 5)
        : ((i & 4) != 0 ? 7 : 4)) : ((i & 2) != 0 ? ((i & 4) != 0 ? 8 : 7)
        : ((i & 4) != 0 ? 7 : 6));
      wb(1'b1, 4'h0, 4'hf, cw);
      window(i[0], 3'b001, 3'b001);
    end
    // ce low freezes the window count: four frozen edges push the end out
    wb(1'b1, 4'h0, 4'hf, 32'h9 | (32'h1 << 15));
    ctrl.send_write(1'b0);
    edges(7);
    check("term before freeze", 32'h4, {29'h0, term});
    @(posedge clk);
    ce <= 1'b0;
    repeat (4) @(posedge clk);
    ce <= 1'b1;
    edges(4);
    check("term frozen window", 32'h4, {29'h0, term});
    edges(1);
    check("term after frozen", 32'h1, {29'h0, term});
    // field 000 and field 100 leave dynamic switching off
    on_lat = 7;
    wb(1'b1, 4'h0, 4'hf, 32'h9);
    ctrl.send_write(1'b0);
    edges(on_lat);
    check("term field 000", 32'h1, {29'h0, term});
    wb(1'b1, 4'h0, 4'hf, 32'h9 | (32'h4 << 15));
    ctrl.send_write(1'b0);
    edges(on_lat);
    check("term field 100", 32'h1, {29'h0, term});
    // clocked pin: nominal after the turn-on latency, then window over it
    ctrl.set_odt(1'b1);
    edges(on_lat - 1);
    check("pin before on", 32'h1, {29'h0, term});
    edges(1);
    check("pin nominal", 32'h2, {29'h0, term});
    wb(1'b1, 4'h0, 4'hf, 32'h9 | (32'h2 << 15));
    off_lat = 4;
    window(1'b1, 3'b010, 3'b010);
    ctrl.set_odt(1'b0);
    edges(on_lat - 1);
    check("pin before off", 32'h2, {29'h0, term});
    edges(1);
    check("pin park", 32'h1, {29'h0, term});
    // write latency 3 floors the pin delay at a single edge
    wb(1'b1, 4'h0, 4'hf, 32'h3);
    ctrl.set_odt(1'b1);
    edges(1);
    check("pin nominal short", 32'h2, {29'h0, term});
    ctrl.set_odt(1'b0);
    edges(1);
    check("pin park short", 32'h1, {29'h0, term});
    // dll off: write field cleared by the controller, pin acts at once
    wb(1'b1, 4'h0, 4'hf, 32'h29 | (32'h1 << 14));
    edges(1);
    check("async flag", 32'h1, {31'h0, async_mode});
    wb(1'b0, 4'h4, 4'hf, 32'h0);
    check("status async", 32'h9, rd);
    ctrl.set_odt(1'b1);
    #1;
    check("async nominal", 32'h2, {29'h0, term});
    ctrl.set_odt(1'b0);
    #1;
    check("async park", 32'h1, {29'h0, term});
    ctrl.send_write(1'b0);
    edges(on_lat + 1);
    check("async write ignored", 32'h1, {29'h0, term});
    print_verdict();
  end
endmodule // term_select_test

`default_nettype wire
